/* File: common/uil_regs.svh */
// Register offsets, field positions and timing counts for the interrupt logic.
// Assumes A2-A0 addressing with the divisor latch and enhanced bank deselected.
`ifndef UIL_REGS_SVH
`define UIL_REGS_SVH
`define UIL_OFF_RHR        3'h0
`define UIL_OFF_THR        3'h0
`define UIL_OFF_IER        3'h1
`define UIL_OFF_ISR        3'h2
`define UIL_OFF_LSR        3'h5
`define UIL_OFF_MSR        3'h6
`define UIL_IER_RESET      8'h00
`define UIL_IER_LOW_MASK   8'h0F
`define UIL_CODE_LINE      6'h06
`define UIL_CODE_TIMEOUT   6'h0C
`define UIL_CODE_RXDATA    6'h04
`define UIL_CODE_TXREADY   6'h02
`define UIL_CODE_MODEM     6'h00
`define UIL_CODE_XOFF      6'h10
`define UIL_CODE_PINS      6'h20
`define UIL_CODE_NONE      6'h01
`define UIL_TO_CHARS       4
`define UIL_TO_EXTRA_BITS  7'h0C
`endif

/* File: common/uil_pkg.sv */
// Types shared by the interrupt logic and its surroundings.
// Assumes host strobes are already one-cycle pulses on sys_clk.
package uil_pkg;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] data;
  } uil_bus_t;
  typedef struct packed {
    logic rxPush;
    logic rxPushErr;
    logic holdErrArrive;
    logic overrun;
    logic bitTick;
    logic modemDelta;
    logic xonXoff;
    logic specialChar;
    logic wakeUp;
  } uil_events_t;
endpackage : uil_pkg

/* File: src/uil_interrupt_logic.sv */
// Interrupt enable, status encoding, priority and clearing of the UART core.
// Assumes FIFO levels, error bits and event pulses come from core logic on sys_clk.
`timescale 1ns/100ps
`include "uil_regs.svh"
// Notes on behaviour
// - FIFO mode with receive enable: interrupt while level at or above trigger.
// - Data ready flag set on push into FIFO, cleared when FIFO empty.
// - FIFO on and enables 0-3 clear selects polled mode.
// - Line status bits report data, overrun, holding errors, transmit, FIFO error.
// - Enable bit 0 gates receive data interrupt; non-FIFO uses non-empty holding.
// - Enable bit 1 gates transmit ready; enabling while empty raises it.
// - Enable bit 2 gates line status interrupt from overrun or holding errors.
// - Error-at-receive mode flags errors when character enters FIFO.
// - Enable bit 3 gates modem status interrupt.
// - Enable bits 4-7 writable only with enhanced functions on.
// - Enable bit 7 with auto CTS: rising CTS raises interrupt.
// - Enable bit 6 with auto RTS: rising RTS output raises interrupt.
// - Time-out after four characters plus twelve bits, cleared by holding read.
// - Transmit ready cleared by status read or transmit holding write.
// - Line read clears line; modem read clears modem and pin interrupts.
// - Status read clears Xon/Xoff and wake; next character clears special.
// - Wake-up raises interrupt on leaving sleep, coded as no interrupt.
// - Priority: line, time-out, receive, transmit, modem, Xoff, pins.
// - Status bits 5:0 carry the fixed code of the reported source.
// - Status read returns only the highest pending source.
// - Status bit 0 is low while any interrupt other than wake-up pends.
// - Bits 4,5 need enhanced functions; bits 7:6 show FIFO enable.
module uil_interrupt_logic (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  // Host register port
  input  wire uil_pkg::uil_bus_t    hostBus,
  input  wire logic                 divisorLatch,
  output logic      [7:0]           regRdData,
  output logic                      hostIrq,
  // Configuration from other registers
  input  wire logic                 fifoEnable,
  input  wire logic                 enhancedEnable,
  input  wire logic                 errorsAtReceive,
  input  wire logic                 wakeIntEnable,
  input  wire logic                 autoCtsEnable,
  input  wire logic                 autoRtsEnable,
  input  wire logic [3:0]           charBits,
  // Core status and events
  input  wire logic [6:0]           rxCount,
  input  wire logic [6:0]           rxTrigLevel,
  input  wire logic [6:0]           txCount,
  input  wire logic [6:0]           txTrigLevel,
  input  wire logic                 txAllEmpty,
  input  wire logic [2:0]           rhrErrBits,
  input  wire logic                 rxFifoErrAny,
  input  wire uil_pkg::uil_events_t events,
  // Flow-control pins
  input  wire logic                 ctsHigh,
  input  wire logic                 rtsHigh,
  // Mode outputs
  output logic                      polledMode,
  output logic                      sleepEnable
);
  logic [7:0] interrupt_enable;
  logic       overrunFlag;
  logic       lineFlag;
  logic       toFlag;
  logic [6:0] toCount;
  logic       txFlag;
  logic       txArm;
  logic       modemFlag;
  logic       xoffFlag;
  logic       specialFlag;
  logic       pinFlag;
  logic       wakeFlag;
  logic       ctsSync1;
  logic       ctsSync2;
  logic       ctsPrev;
  logic       rtsPrev;
  logic [7:0] next_ier;
  logic       next_overrunFlag;
  logic       next_lineFlag;
  logic       next_toFlag;
  logic [6:0] next_toCount;
  logic       next_txFlag;
  logic       next_txArm;
  logic       next_modemFlag;
  logic       next_xoffFlag;
  logic       next_specialFlag;
  logic       next_pinFlag;
  logic       next_wakeFlag;
  logic [7:0] next_regRdData;
  logic       rhrRead;
  logic       thrWrite;
  logic       ierWrite;
  logic       isrRead;
  logic       lsrRead;
  logic       msrRead;
  logic       rxPend;
  logic       txCond;
  logic       linePend;
  logic       toPend;
  logic       txPend;
  logic       modemPend;
  logic       xoffPend;
  logic       anyPend;
  logic       ctsRise;
  logic       rtsRise;
  logic       lineSet;
  logic [6:0] toLimit;
  logic [5:0] isrCode;
  logic [7:0] line_status_reg;

  assign rhrRead  = hostBus.rd && !divisorLatch && hostBus.addr == `UIL_OFF_RHR;
  assign thrWrite = hostBus.wr && !divisorLatch && hostBus.addr == `UIL_OFF_THR;
  assign ierWrite = hostBus.wr && !divisorLatch && hostBus.addr == `UIL_OFF_IER;
  assign isrRead  = hostBus.rd && hostBus.addr == `UIL_OFF_ISR;
  assign lsrRead  = hostBus.rd && hostBus.addr == `UIL_OFF_LSR;
  assign msrRead  = hostBus.rd && hostBus.addr == `UIL_OFF_MSR;

  assign rxPend = interrupt_enable[0] && (fifoEnable ? rxCount >= rxTrigLevel : rxCount != 7'h00);
  assign txCond = fifoEnable ? (txCount < txTrigLevel || txCount == 7'h00) : txCount == 7'h00;
  assign lineSet = events.overrun
                 || (errorsAtReceive ? events.rxPushErr : events.holdErrArrive);
  assign ctsRise = ctsPrev == 1'b0 && ctsSync2;
  assign rtsRise = !rtsPrev && rtsHigh;
  assign toLimit = 7'(`UIL_TO_CHARS * charBits + `UIL_TO_EXTRA_BITS);

  assign linePend  = interrupt_enable[2] && lineFlag;
  assign toPend    = interrupt_enable[0] && toFlag;
  assign txPend    = interrupt_enable[1] && txFlag;
  assign modemPend = interrupt_enable[3] && modemFlag;
  assign xoffPend  = enhancedEnable && interrupt_enable[5] && (xoffFlag || specialFlag);
  assign anyPend   = linePend || toPend || rxPend || txPend || modemPend || xoffPend
                   || (enhancedEnable && pinFlag);

  // Highest pending source only
  always_comb
  begin
    if (linePend) isrCode = `UIL_CODE_LINE;
    else if (toPend) isrCode = `UIL_CODE_TIMEOUT;
    else if (rxPend) isrCode = `UIL_CODE_RXDATA;
    else if (txPend) isrCode = `UIL_CODE_TXREADY;
    else if (modemPend) isrCode = `UIL_CODE_MODEM;
    else if (xoffPend) isrCode = `UIL_CODE_XOFF;
    else if (enhancedEnable && pinFlag) isrCode = `UIL_CODE_PINS;
    else isrCode = `UIL_CODE_NONE;
  end

  assign line_status_reg = {rxFifoErrAny, txAllEmpty, txCount == 7'h00, rhrErrBits, overrunFlag,
                rxCount != 7'h00};

  always_comb
  begin
    next_ier = interrupt_enable;
    if (ierWrite)
      next_ier = enhancedEnable ? hostBus.data
               : (interrupt_enable & ~`UIL_IER_LOW_MASK) | (hostBus.data & `UIL_IER_LOW_MASK);
    next_overrunFlag = events.overrun || (overrunFlag && !lsrRead);
    next_lineFlag    = lineSet || (lineFlag && !lsrRead);
    // Time-out timer restarts on receive FIFO push or holding read
    next_toCount = toCount;
    next_toFlag  = toFlag && !rhrRead;
    if (events.rxPush || rhrRead || rxCount == 7'h00 || !fifoEnable)
      next_toCount = 7'h00;
    else if (events.bitTick && !toFlag)
    begin
      next_toCount = toCount + 7'h01;
      if (toCount + 7'h01 >= toLimit)
        next_toFlag = 1'b1;
    end
    next_txArm  = interrupt_enable[1] && txCond;
    next_txFlag = (next_txArm && !txArm)
               || (txFlag && !thrWrite && !(isrRead && isrCode == `UIL_CODE_TXREADY));
    next_modemFlag = events.modemDelta || (modemFlag && !msrRead);
    next_pinFlag = (enhancedEnable && ((interrupt_enable[7] && autoCtsEnable && ctsRise)
                 || (interrupt_enable[6] && autoRtsEnable && rtsRise)))
                 || (pinFlag && !msrRead);
    next_xoffFlag = events.xonXoff || (xoffFlag && !(isrRead && isrCode == `UIL_CODE_XOFF));
    next_specialFlag = events.specialChar
                    || (specialFlag && !events.rxPush
                        && !(isrRead && isrCode == `UIL_CODE_XOFF));
    next_wakeFlag = (wakeIntEnable && events.wakeUp) || (wakeFlag && !isrRead);
    // Read data registered before the clear lands
    next_regRdData = regRdData;
    if (isrRead)
      next_regRdData = {{2{fifoEnable}}, isrCode};
    else if (hostBus.rd && !divisorLatch && hostBus.addr == `UIL_OFF_IER)
      next_regRdData = interrupt_enable;
    else if (lsrRead)
      next_regRdData = line_status_reg;
    else if (hostBus.rd)
      next_regRdData = 8'h00;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      interrupt_enable         <= `UIL_IER_RESET;
      overrunFlag <= 1'b0;
      lineFlag    <= 1'b0;
      toFlag      <= 1'b0;
      toCount     <= 7'h00;
      txFlag      <= 1'b0;
      txArm       <= 1'b0;
      modemFlag   <= 1'b0;
      xoffFlag    <= 1'b0;
      specialFlag <= 1'b0;
      pinFlag     <= 1'b0;
      wakeFlag    <= 1'b0;
      regRdData   <= 8'h00;
      ctsSync1    <= 1'b0;
      ctsSync2    <= 1'b0;
      ctsPrev     <= 1'b0;
      rtsPrev     <= 1'b0;
    end
    else
    begin
      interrupt_enable         <= next_ier;
      overrunFlag <= next_overrunFlag;
      lineFlag    <= next_lineFlag;
      toFlag      <= next_toFlag;
      toCount     <= next_toCount;
      txFlag      <= next_txFlag;
      txArm       <= next_txArm;
      modemFlag   <= next_modemFlag;
      xoffFlag    <= next_xoffFlag;
      specialFlag <= next_specialFlag;
      pinFlag     <= next_pinFlag;
      wakeFlag    <= next_wakeFlag;
      regRdData   <= next_regRdData;
      ctsSync1    <= ctsHigh;
      ctsSync2    <= ctsSync1;
      ctsPrev     <= ctsSync2;
      rtsPrev     <= rtsHigh;
    end
  end

  assign hostIrq     = anyPend || wakeFlag;
  assign polledMode  = fifoEnable && interrupt_enable[3:0] == 4'h0;
  assign sleepEnable = interrupt_enable[4];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  AST_RXTRIG: assert property (fifoEnable && interrupt_enable[0] && !linePend && !toPend
    && rxCount >= rxTrigLevel |-> isrCode == `UIL_CODE_RXDATA)
    else $error("receive trigger not reported");
  AST_DRDY: assert property (line_status_reg[0] == (rxCount != 7'h00))
    else $error("data ready flag wrong");
  AST_POLLED: assert property (polledMode |-> !rxPend && !txPend
    && !linePend && !modemPend)
    else $error("interrupt raised in polled mode");
  AST_LSRHI: assert property (line_status_reg[7:5] == {rxFifoErrAny, txAllEmpty, txCount == 7'h00})
    else $error("line status high bits wrong");
  AST_TXENABLE: assert property (ierWrite && hostBus.data[1] && !interrupt_enable[1] && txCond
    && !thrWrite ##1 txCond |=> txFlag)
    else $error("enabling transmit while empty gave no interrupt");
  AST_LINESET: assert property (interrupt_enable[2] && events.overrun |=> isrCode == `UIL_CODE_LINE)
    else $error("overrun did not raise line interrupt");
  AST_LSRCLR: assert property (lsrRead && !lineSet |=> !lineFlag)
    else $error("line read did not clear");
  AST_IERLOCK: assert property (ierWrite && !enhancedEnable |=> interrupt_enable[7:4] == $past(interrupt_enable[7:4]))
    else $error("upper enables written while locked");
  AST_TOCLR: assert property (toFlag && rhrRead |=> !toFlag)
    else $error("time-out not cleared by holding read");
  AST_TXCLR: assert property (txFlag && thrWrite && txArm ##1 txArm |-> !txFlag)
    else $error("transmit write did not clear");
  AST_CTS: assert property (enhancedEnable && interrupt_enable[7] && autoCtsEnable && ctsRise
    |=> pinFlag)
    else $error("CTS rise lost");
  AST_MSRCLR: assert property (msrRead && !events.modemDelta && !ctsRise && !rtsRise
    |=> !modemFlag && !pinFlag)
    else $error("modem read did not clear");
  AST_ISR0: assert property (isrCode[0] == !anyPend)
    else $error("status bit 0 wrong");
  AST_IRQ: assert property (isrRead && hostIrq && !wakeFlag |=> regRdData[0] == 1'b0)
    else $error("interrupt output disagrees with status");
  AST_RDPRE: assert property (isrRead |=> regRdData == {{2{$past(fifoEnable)}},
    $past(isrCode)})
    else $error("status read not pre-clear value");
  AST_RXNOFIFO: assert property (!fifoEnable && interrupt_enable[0] && rxCount != 7'h00 && !linePend
    && !toPend |-> isrCode == `UIL_CODE_RXDATA)
    else $error("non-FIFO receive data not reported");
  AST_ERRRX: assert property (interrupt_enable[2] && errorsAtReceive && events.rxPushErr
    |=> linePend)
    else $error("error at receive not flagged");
  AST_XOFFCLR: assert property (isrRead && isrCode == `UIL_CODE_XOFF && !events.xonXoff
    && !events.specialChar |=> !xoffFlag && !specialFlag)
    else $error("Xon/Xoff read did not clear");
  AST_WAKE: assert property (wakeIntEnable && events.wakeUp |=> hostIrq)
    else $error("wake-up not raised");
  AST_PRIO: assert property (linePend && toPend |-> isrCode == `UIL_CODE_LINE)
    else $error("line status not above time-out");

  // Main scenarios
  COV_CTS: cover property (ctsRise ##1 pinFlag);
  COV_RXTO: cover property (toFlag && rhrRead ##1 !toFlag);
  COV_TXISR: cover property (txPend && isrRead ##1 !txFlag);
  COV_LINE_OVER_RX: cover property (linePend && rxPend);
  COV_WAKE: cover property (wakeFlag && !anyPend && hostIrq);
endmodule : uil_interrupt_logic

/* File: verification/uil_host_model.sv */
// Host processor model for the register port of the interrupt logic.
// Assumes the bench calls access; strobes launch at falling edges of sys_clk.
`timescale 1ns/100ps
module uil_host_model (
  // Clock
  input  wire logic         sys_clk,
  // Register port
  output uil_pkg::uil_bus_t hostBus,
  input  wire logic [7:0]   regRdData
);
  initial hostBus = '0;
  // One-cycle strobe; read data is taken at the following falling edge
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge sys_clk);
    hostBus = '{rd: !wr, wr: wr, addr: a, data: d};
    @(negedge sys_clk);
    q = regRdData;
    hostBus = '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
  endtask : access
endmodule : uil_host_model

/* File: verification/tb.sv */
// Self-checking bench for the interrupt logic with a reference of pending levels.
// Assumes the design, package and host model are compiled before it.
`timescale 1ns/100ps
`include "uil_regs.svh"
module tb;
  localparam int TO_LIM = 4 * 10 + 12;
  logic sys_clk, reset, hostIrq, polledMode, sleepEnable, fifoEnable, enhancedEnable;
  logic errorsAtReceive, autoRtsEnable, txAllEmpty, rxFifoErrAny, rtsHigh;
  logic autoCtsEnable, wakeIntEnable, ctsHigh;
  logic [2:0]  rhrErrBits;
  logic [6:0]  rxCount, rxTrigLevel, txCount, txTrigLevel;
  logic [7:0]  regRdData, q;
  logic [31:0] rnd;
  uil_pkg::uil_bus_t    hostBus;
  uil_pkg::uil_events_t events;
  int n_fail, comparisons;
  int pend[8];
  int codes[8] = '{`UIL_CODE_NONE, `UIL_CODE_LINE, `UIL_CODE_TIMEOUT, `UIL_CODE_RXDATA,
                   `UIL_CODE_TXREADY, `UIL_CODE_MODEM, `UIL_CODE_XOFF, `UIL_CODE_PINS};

  uil_interrupt_logic uil_interrupt_logic_i (
    .sys_clk(sys_clk), .reset(reset), .hostBus(hostBus), .divisorLatch(1'b0),
    .regRdData(regRdData), .hostIrq(hostIrq), .fifoEnable(fifoEnable),
    .enhancedEnable(enhancedEnable), .errorsAtReceive(errorsAtReceive),
    .wakeIntEnable(wakeIntEnable), .autoCtsEnable(autoCtsEnable), .autoRtsEnable(autoRtsEnable),
    .charBits(4'hA), .rxCount(rxCount), .rxTrigLevel(rxTrigLevel), .txCount(txCount),
    .txTrigLevel(txTrigLevel), .txAllEmpty(txAllEmpty), .rhrErrBits(rhrErrBits),
    .rxFifoErrAny(rxFifoErrAny), .events(events), .ctsHigh(ctsHigh), .rtsHigh(rtsHigh),
    .polledMode(polledMode), .sleepEnable(sleepEnable));
  uil_host_model uil_host_model_i (.sys_clk(sys_clk), .hostBus(hostBus),
    .regRdData(regRdData));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Lowest-numbered pending level wins; none gives the idle code
  function automatic logic [7:0] exp_isr();
    int lvl;
    lvl = 0;
    for (int i = 7; i >= 1; i--)
      if (pend[i] != 0)
        lvl = i;
    return {fifoEnable, fifoEnable, 6'(codes[lvl])};
  endfunction : exp_isr
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic rd(input logic [2:0] a);
    uil_host_model_i.access(1'b0, a, 8'h00, q);
  endtask : rd
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    uil_host_model_i.access(1'b1, a, d, q);
  endtask : wr
  task automatic pulse(input logic [8:0] e);
    @(negedge sys_clk);
    events = e;
    @(negedge sys_clk);
    events = '0;
  endtask : pulse
  task automatic chk_isr();
    logic [7:0] e;
    @(negedge sys_clk);
    e = exp_isr();
    check({7'h00, hostIrq}, {7'h00, !e[0]}, "interrupt output");
    rd(`UIL_OFF_ISR);
    check(q, e, "status read");
    if (e[5:0] == `UIL_CODE_TXREADY || e[5:0] == `UIL_CODE_XOFF)
      pend[e[5:0] == `UIL_CODE_XOFF ? 6 : 4] = 0;
  endtask : chk_isr
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    $display("Error at %0t ns: run did not finish", $time);
    final_report();
  end
  initial
  begin
    reset = 1'b1;
    fifoEnable = 1'b1;
    {errorsAtReceive, autoRtsEnable, enhancedEnable, txAllEmpty, rxFifoErrAny, rtsHigh} = '0;
    {autoCtsEnable, wakeIntEnable, ctsHigh} = '0;
    {rhrErrBits, rxCount} = '0;
    {rxTrigLevel, txTrigLevel, txCount} = {7'h08, 7'h04, 7'h0A};
    events = '0;
    rnd = 32'h51853723;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    chk_isr();
    rd(`UIL_OFF_IER);
    check(q, `UIL_IER_RESET, "enable reset");
    check({7'h00, polledMode}, 8'h01, "polled");
    fifoEnable = 1'b0;
    chk_isr();
    fifoEnable = 1'b1;
    $display("Test reset done");
    wr(`UIL_OFF_IER, 8'hFF);
    rd(`UIL_OFF_IER);
    check(q, `UIL_IER_LOW_MASK, "upper enables refused");
    check({6'h00, polledMode, sleepEnable}, 8'h00, "modes");
    wr(`UIL_OFF_IER, 8'h00);
    $display("Test enable mask done");
    txCount = 7'h00;
    wr(`UIL_OFF_IER, 8'h02);
    pend[4] = 1;
    chk_isr();
    chk_isr();
    txCount = 7'h05;
    @(negedge sys_clk);
    txCount = 7'h00;
    pend[4] = 1;
    chk_isr();
    txCount = 7'h05;
    @(negedge sys_clk);
    txCount = 7'h00;
    @(negedge sys_clk);
    check({7'h00, hostIrq}, 8'h01, "transmit ready again");
    wr(`UIL_OFF_THR, 8'h5A);
    pend[4] = 0;
    chk_isr();
    txCount = 7'h0A;
    $display("Test transmit ready done");
    wr(`UIL_OFF_IER, 8'h01);
    for (int i = 7; i <= 9; i++)
    begin
      rxCount = 7'(i % 9);
      pend[3] = (i == 8);
      chk_isr();
    end
    rxCount = 7'h01;
    pulse(9'h100);
    repeat (TO_LIM - 1) pulse(9'h010);
    chk_isr();
    pulse(9'h010);
    pend[2] = 1;
    chk_isr();
    rd(`UIL_OFF_RHR);
    pend[2] = 0;
    chk_isr();
    rxCount = 7'h00;
    $display("Test receive done");
    enhancedEnable = 1'b1;
    autoRtsEnable = 1'b1;
    wr(`UIL_OFF_IER, 8'hFF);
    check({7'h00, sleepEnable}, 8'h01, "sleep enable");
    rtsHigh = 1'b1;
    pulse(9'h02C);
    {pend[1], pend[5], pend[6], pend[7]} = {4{32'd1}};
    chk_isr();
    rd(`UIL_OFF_LSR);
    check(q & 8'h02, 8'h02, "overrun flag");
    pend[1] = 0;
    chk_isr();
    rd(`UIL_OFF_MSR);
    {pend[5], pend[7]} = '0;
    chk_isr();
    chk_isr();
    rtsHigh = 1'b0;
    pulse(9'h000);
    rtsHigh = 1'b1;
    pend[7] = 1;
    chk_isr();
    rd(`UIL_OFF_MSR);
    pend[7] = 0;
    chk_isr();
    autoCtsEnable = 1'b1;
    ctsHigh = 1'b1;
    pend[7] = 1;
    repeat (2) @(negedge sys_clk);
    chk_isr();
    rd(`UIL_OFF_MSR);
    pend[7] = 0;
    chk_isr();
    wakeIntEnable = 1'b1;
    pulse(9'h001);
    check({7'h00, hostIrq}, 8'h01, "wake output");
    rd(`UIL_OFF_ISR);
    check(q, exp_isr(), "wake status");
    check({7'h00, hostIrq}, 8'h00, "wake cleared");
    for (int i = 0; i < 2; i++)
    begin
      errorsAtReceive = i[0];
      pulse(i[0] ? 9'h080 : 9'h040);
      pend[1] = 1;
      chk_isr();
      rd(`UIL_OFF_LSR);
      pend[1] = 0;
      chk_isr();
    end
    $display("Test priority done");
    wr(`UIL_OFF_IER, 8'h00);
    rxCount = 7'h03;
    pulse(9'h100);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      {txAllEmpty, rxFifoErrAny, rhrErrBits} = rnd[4:0];
      txCount = rnd[5] ? 7'h00 : 7'h05;
      txTrigLevel = {1'b0, rnd[13:8]};
      rd(`UIL_OFF_LSR);
      check(q, {rnd[3], rnd[4], rnd[5], rnd[2:0], 2'b01}, "line status");
    end
    rxCount = 7'h00;
    rd(`UIL_OFF_LSR);
    check(q & 8'h01, 8'h00, "data ready cleared");
    $display("Test line status done");
    final_report();
  end
endmodule : tb
